/* hw/vpic_arb_if.sv */
`timescale 1ns/100ps
interface vpic_arb_if import vpic_pkg::*; ();
	logic [NUM_SRC-1:0]        flags;     // Request flags
	logic [NUM_SRC-1:0]        enables;   // Source enables
	logic [NUM_SRC*PRIO_W-1:0] prios;     // Packed priority fields
	logic [LVL_W-1:0]          cpu_level; // Current CPU level
	logic                      win_valid; // A user source is eligible
	logic [VEC_W-1:0]          win_index; // Winning request number
	logic [PRIO_W-1:0]         win_prio;  // Winning priority

	// Arbiter end
	modport arbiter (input flags, input enables, input prios, input cpu_level,
		output win_valid, output win_index, output win_prio);
	// Register file end
	modport source (output flags, output enables, output prios, output cpu_level,
		input win_valid, input win_index, input win_prio);
endinterface

/* hw/vpic_arbiter.sv */
`timescale 1ns/100ps
module vpic_arbiter import vpic_pkg::*;
(
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       reset_in,
	// Request view and result
	vpic_arb_if.arbiter    arb
);

	// Registered winner
	typedef struct packed
	{
		logic              valid;
		logic [VEC_W-1:0]  index;
		logic [PRIO_W-1:0] prio;
	} vpic_arb_state_t;

	vpic_arb_state_t q;  // Current winner
	vpic_arb_state_t d;  // Next winner

	// Scan from the top so that equal priority ends on the lowest number
	always_comb
	begin
		logic [PRIO_W-1:0] p;
		p = '0;
		d = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			p = arb.prios[i*PRIO_W +: PRIO_W];
			// Flagged, enabled, above the CPU level, msb clear
			if (arb.flags[i] && arb.enables[i] && (p != '0) && ({1'b0, p} > arb.cpu_level) && !arb.cpu_level[LVL_W-1])
			begin
				// Ties go to the lower request number
				if (!d.valid || (p >= d.prio))
				begin
					d.valid = 1'b1;
					d.index = VEC_W'(i);
					d.prio  = p;
				end
			end
		end
	end

	// Winner register
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			q <= '0;
		else
			q <= d;
	end

	assign arb.win_valid = q.valid;
	assign arb.win_index = q.index;
	assign arb.win_prio  = q.prio;

endmodule

/* hw/vpic_pkg.sv */
package vpic_pkg;

	// Sizes
	localparam int NUM_SRC      = 72;                 // User request lines
	localparam int NUM_EXT      = 5;                  // External request pins
	localparam int NUM_TRAP     = 8;                  // Trap vector slots
	localparam int DW           = 16;                 // Register data width
	localparam int AW           = 8;                  // Register index width
	localparam int PRIO_W       = 3;                  // Priority field width
	localparam int VEC_W        = 7;                  // Vector number width
	localparam int LVL_W        = 4;                  // CPU level width
	localparam int TADDR_W      = 24;                 // Program address width
	localparam int FLAG_REGS    = 5;                  // Flag and enable words
	localparam int PRIO_REGS    = 18;                 // Priority words
	localparam int PRIO_PER_REG = 4;                  // Fields per priority word
	localparam int PRIO_STRIDE  = 4;                  // Bit spacing of fields
	localparam int IRQ_W        = 2;                  // Interrupt status width

	// Register indices
	localparam logic [AW-1:0] ADDR_GC1       = 8'h00;
	localparam logic [AW-1:0] ADDR_GC2       = 8'h01;
	localparam logic [AW-1:0] ADDR_FLAG_BASE = 8'h02;
	localparam logic [AW-1:0] ADDR_EN_BASE   = 8'h08;
	localparam logic [AW-1:0] ADDR_PRIO_BASE = 8'h10;
	localparam logic [AW-1:0] ADDR_PEND      = 8'h22;
	localparam logic [AW-1:0] ADDR_STATUS_WD = 8'h23;
	localparam logic [AW-1:0] ADDR_CORE_CTRL = 8'h24;
	localparam logic [AW-1:0] ADDR_IRQ_STAT  = 8'h25;
	localparam logic [AW-1:0] ADDR_IRQ_MASK  = 8'h26;

	// Field positions
	localparam int GC1_NEST_BIT   = 15;               // Nesting disable
	localparam int GC2_ALT_BIT    = 15;               // Alternate table select
	localparam int STATUS_IPL_LSB = 5;                // Low level bits 7:5
	localparam int CORE_MSB_BIT   = 3;                // Level msb
	localparam int PEND_LVL_LSB   = 8;                // Pending level 11:8
	localparam int IRQ_PEND_BIT   = 0;                // New pending vector event
	localparam int IRQ_TRAP_BIT   = 1;                // Trap event
	localparam logic [DW-1:0] GC1_WR_MASK = 16'h803e; // Nesting bit and trap flags
	localparam logic [DW-1:0] GC2_WR_MASK = 16'h801f; // Alt select and pin polarity

	// Trap flag bit in the first control word, indexed by trap vector
	localparam int TRAP_FLAG_BIT [NUM_TRAP] = '{0, 1, 3, 2, 4, 5, 0, 0};
	localparam logic [NUM_TRAP-1:0] TRAP_IMPL = 8'h3e; // Vectors 1..5 exist

	// Request numbers of the external pins
	localparam int EXT_SRC [NUM_EXT] = '{0, 20, 29, 53, 54};

	// Vector table layout
	localparam logic [VEC_W-1:0]   USER_VEC_BASE  = 7'h08;
	localparam logic [TADDR_W-1:0] TABLE_BASE     = 24'h000004;
	localparam logic [TADDR_W-1:0] ALT_TABLE_OFFS = 24'h000100;
	localparam logic [LVL_W-1:0]   TRAP_LEVEL_TOP = 4'hf;

	// Values after reset
	localparam logic [DW-1:0]    RST_GC1       = 16'h0000;
	localparam logic [DW-1:0]    RST_GC2       = 16'h0000;
	localparam logic [LVL_W-1:0] RST_CPU_LEVEL = 4'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ_MASK  = 2'h0;

endpackage

/* hw/vpic_top.sv */
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module vpic_top import vpic_pkg::*;
(
	// Clock and reset
	input  wire logic                 CLK_IN,
	input  wire logic                 RESET_IN,
	// Register port
	// Read data follow one cycle after the read strobe
	input  wire logic [AW-1:0]        ADDR_IN,
	input  wire logic [DW-1:0]        WDATA_IN,
	input  wire logic                 WR_STROBE_IN,
	input  wire logic                 RD_STROBE_IN,
	output logic      [DW-1:0]        RDATA_OUT,
	// Event sources
	// Pins are asynchronous; peripheral and trap lines are not
	input  wire logic [NUM_SRC-1:0]   PERIPH_REQ_IN,
	input  wire logic [NUM_EXT-1:0]   EXT_PIN_IN,
	input  wire logic [NUM_TRAP-1:0]  TRAP_IN,
	// Core side
	// Acknowledge takes the pending level; restore sets any level
	output logic                      INT_REQ_OUT,
	output logic      [VEC_W-1:0]     PENDING_VECTOR_OUT,
	output logic      [LVL_W-1:0]     PENDING_LEVEL_OUT,
	output logic      [TADDR_W-1:0]   VECTOR_ADDR_OUT,
	input  wire logic                 INT_ACK_IN,
	input  wire logic                 RESTORE_IN,
	input  wire logic [LVL_W-1:0]     RESTORE_LEVEL_IN,
	output logic      [LVL_W-1:0]     CPU_LEVEL_OUT,
	// Interrupt to the system
	output logic                      IRQ_OUT
);

	// All state of the block
	typedef struct packed
	{
		// Pin edge path
		logic [NUM_EXT-1:0]        sync1;      // Pin synchroniser, first stage
		logic [NUM_EXT-1:0]        sync2;      // Pin synchroniser, second stage
		logic [NUM_EXT-1:0]        prev;       // Previous synced pin level
		// Software-visible control
		logic [DW-1:0]             gc1;        // Global control one
		logic [DW-1:0]             gc2;        // Global control two
		// Per-source storage
		logic [NUM_SRC-1:0]        flags;      // Request flags
		logic [NUM_SRC-1:0]        enables;    // Source enables
		logic [NUM_SRC*PRIO_W-1:0] prios;      // Priority fields
		// CPU level, split as software sees it
		logic [PRIO_W-1:0]         ipl_low;    // Level bits 2:0
		logic                      ipl_msb;    // Level bit 3
		// Pending latch toward the core
		logic                      pend_valid; // Request to the core
		logic [VEC_W-1:0]          pend_vec;   // Pending vector number
		logic [LVL_W-1:0]          pend_lvl;   // Pending level
		logic [TADDR_W-1:0]        vec_addr;   // Table entry address
		// Bus and interrupt side
		logic [DW-1:0]             rdata;      // Read data
		logic [IRQ_W-1:0]          irq_stat;   // Sticky event bits
		logic [IRQ_W-1:0]          irq_mask;   // Event mask
	} vpic_state_t;

	vpic_state_t q;  // Registered state
	vpic_state_t d;  // Next state

	vpic_arb_if arb_bus ();  // Link to the arbiter

	// Timing from a peripheral pulse to the core:
	//   edge 0 sets the flag,
	//   edge 1 registers the arbiter winner,
	//   edge 2 latches vector, level and address.
	// Traps skip the arbiter and are one edge quicker.
	// Trade-off: one cycle of latency buys a short compare chain
	// Arbiter sees the registered flags, so its answer lags one cycle
	// The arbiter shares this block's reset
	vpic_arbiter u_arbiter
	(
		.clk_in   (CLK_IN),
		.reset_in (RESET_IN),
		.arb      (arb_bus.arbiter)
	);

	assign arb_bus.flags     = q.flags;
	assign arb_bus.enables   = q.enables;
	assign arb_bus.prios     = q.prios;
	assign arb_bus.cpu_level = {q.ipl_msb, q.ipl_low};

	// Next state of everything
	// Order inside matters: writes first, hardware sets after,
	// so that a set in the same cycle as a clearing write wins.
	// Level changes land before the pending recheck, so an
	// acknowledge never leaves a stale request standing.
	// One pass, no loops back: everything settles in one cycle
	always_comb
	begin
		// Event gathering
		logic [NUM_SRC-1:0]  set_mask;  // Events this cycle
		logic [NUM_EXT-1:0]  pin_edge;  // Active pin edges
		logic [NUM_TRAP-1:0] trap_flag; // Trap flags by vector

		// Level and trap choice
		logic [LVL_W-1:0]    cur_lvl;   // Level after this cycle
		logic [LVL_W-1:0]    trap_lvl;  // Level of a trap candidate
		logic                trap_hit;  // Some trap is eligible
		logic [VEC_W-1:0]    trap_vec;  // Winning trap vector
		logic [LVL_W-1:0]    trap_win;  // Winning trap level

		// User choice and bus side
		logic                user_ok;   // Arbiter result still eligible
		logic [DW-1:0]       rd_word;   // Read mux
		logic [IRQ_W-1:0]    events;    // Interrupt events
		set_mask  = '0;
		pin_edge  = '0;
		trap_flag = '0;
		cur_lvl   = '0;
		trap_lvl  = '0;
		trap_hit  = 1'b0;
		trap_vec  = '0;
		trap_win  = '0;
		user_ok   = 1'b0;
		rd_word   = '0;
		events    = '0;
		d = q;

		// Pins pass two flops before the edge detector
		// Only stage two is read; stage one may be metastable
		// Reset clears both stages, matching an idle low pin
		d.sync1 = EXT_PIN_IN;
		d.sync2 = q.sync1;
		d.prev  = q.sync2;

		// Polarity bit low means rising edge, high means falling edge
		for (int e = 0; e < NUM_EXT; e++)
		begin
			// Falling edge selected
			if (q.gc2[e])
				pin_edge[e] = q.prev[e] & ~q.sync2[e];
			// Rising edge, the choice after reset
			else
				pin_edge[e] = ~q.prev[e] & q.sync2[e];
		end

		// Peripheral pulses plus pin edges at their request numbers
		// A pin shares its flag with its request line
		set_mask = PERIPH_REQ_IN;
		for (int e = 0; e < NUM_EXT; e++)
			set_mask[EXT_SRC[e]] = set_mask[EXT_SRC[e]] | pin_edge[e];

		// Control words, implemented bits only
		// Unimplemented bits are masked off and read zero
		// Trap flags may be cleared here by writing zero
		if (WR_STROBE_IN && (ADDR_IN == ADDR_GC1))
			d.gc1 = WDATA_IN & GC1_WR_MASK;
		if (WR_STROBE_IN && (ADDR_IN == ADDR_GC2))
			d.gc2 = WDATA_IN & GC2_WR_MASK;

		// Trap causes set their flags; a set beats a clearing write
		// Reserved vectors have no flag and are ignored
		for (int v = 0; v < NUM_TRAP; v++)
		begin
			if (TRAP_IMPL[v] && TRAP_IN[v])
				d.gc1[TRAP_FLAG_BIT[v]] = 1'b1;
		end

		// Flag, enable and priority words in request order
		// Flag and enable words hold sixteen sources each
		// Priority words hold four fields a nibble apart
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (WR_STROBE_IN && (ADDR_IN == ADDR_FLAG_BASE + AW'(i / DW)))
				d.flags[i] = WDATA_IN[i % DW];
			if (WR_STROBE_IN && (ADDR_IN == ADDR_EN_BASE + AW'(i / DW)))
				d.enables[i] = WDATA_IN[i % DW];
			if (WR_STROBE_IN && (ADDR_IN == ADDR_PRIO_BASE + AW'(i / PRIO_PER_REG)))
				d.prios[i*PRIO_W +: PRIO_W] = WDATA_IN[(i % PRIO_PER_REG)*PRIO_STRIDE +: PRIO_W];
		end

		// Hardware only ever sets a flag, and it wins over a clearing write
		// Software may write a one too, handy to test a handler
		d.flags = d.flags | set_mask;

		// Software moves the low level bits unless nesting is disabled
		if (WR_STROBE_IN && (ADDR_IN == ADDR_STATUS_WD) && !q.gc1[GC1_NEST_BIT])
			d.ipl_low = WDATA_IN[STATUS_IPL_LSB +: PRIO_W];
		// The msb has no software write path; only the core moves it
		// Acknowledge takes the level of what was pending
		if (INT_ACK_IN && q.pend_valid)
			{d.ipl_msb, d.ipl_low} = q.pend_lvl;
		// A core return overrides an acknowledge in the same cycle
		if (RESTORE_IN)
			{d.ipl_msb, d.ipl_low} = RESTORE_LEVEL_IN;
		// Everything below compares against this newest level
		cur_lvl = {d.ipl_msb, d.ipl_low};

		// Traps: lowest vector first, each must beat the current level
		// Trap level is fifteen less the vector number
		// Limitation: a trap not above the CPU level waits
		// silently, its flag still set
		for (int v = NUM_TRAP - 1; v >= 0; v--)
		begin
			trap_flag[v] = TRAP_IMPL[v] & q.gc1[TRAP_FLAG_BIT[v]];
			trap_lvl = TRAP_LEVEL_TOP - LVL_W'(v);
			if (trap_flag[v] && (trap_lvl > cur_lvl))
			begin
				trap_hit = 1'b1;
				trap_vec = VEC_W'(v);
				trap_win = trap_lvl;
			end
		end

		// Recheck the lagging arbiter answer against the newest level
		// The answer is a cycle old; a level raised this cycle
		// must still hold it off
		// A zero priority can never pass this compare
		user_ok = arb_bus.win_valid && !cur_lvl[LVL_W-1] && ({1'b0, arb_bus.win_prio} > cur_lvl);

		// Latch the pending vector and its level
		// Nothing pending: vector and level keep their last value
		// Only one source is presented at a time
		d.pend_valid = trap_hit | user_ok;
		// Traps outrank every user source
		if (trap_hit)
		begin
			d.pend_vec = trap_vec;
			d.pend_lvl = trap_win;
		end
		// User vectors start above the trap slots
		else if (user_ok)
		begin
			d.pend_vec = arb_bus.win_index + USER_VEC_BASE;
			d.pend_lvl = {1'b0, arb_bus.win_prio};
		end

		// Each table entry is two words; the alternate table sits above
		// Doubling the vector gives the word offset
		// The table select applies to traps and user sources alike
		d.vec_addr = TABLE_BASE + {16'h0000, d.pend_vec, 1'b0};
		if (q.gc2[GC2_ALT_BIT])
			d.vec_addr = d.vec_addr + ALT_TABLE_OFFS;

		// Read mux; unmapped indices read zero
		// Control words
		if (ADDR_IN == ADDR_GC1)
			rd_word = q.gc1;
		else if (ADDR_IN == ADDR_GC2)
			rd_word = q.gc2;
		// Pending vector word, read only
		else if (ADDR_IN == ADDR_PEND)
			rd_word = {4'h0, q.pend_lvl, 1'b0, q.pend_vec};
		// Low level bits in the status word
		else if (ADDR_IN == ADDR_STATUS_WD)
			rd_word[STATUS_IPL_LSB +: PRIO_W] = q.ipl_low;
		// Level msb, read only
		else if (ADDR_IN == ADDR_CORE_CTRL)
			rd_word[CORE_MSB_BIT] = q.ipl_msb;
		// Status, cleared by this same read
		else if (ADDR_IN == ADDR_IRQ_STAT)
			rd_word[IRQ_W-1:0] = q.irq_stat;
		// Mask
		else if (ADDR_IN == ADDR_IRQ_MASK)
			rd_word[IRQ_W-1:0] = q.irq_mask;
		else
		begin
			// Per-source words are gathered bit by bit
			// Sources past the last one read zero
			// Bit 3 of each priority nibble reads zero
			for (int i = 0; i < NUM_SRC; i++)
			begin
				if (ADDR_IN == ADDR_FLAG_BASE + AW'(i / DW))
					rd_word[i % DW] = q.flags[i];
				if (ADDR_IN == ADDR_EN_BASE + AW'(i / DW))
					rd_word[i % DW] = q.enables[i];
				if (ADDR_IN == ADDR_PRIO_BASE + AW'(i / PRIO_PER_REG))
					rd_word[(i % PRIO_PER_REG)*PRIO_STRIDE +: PRIO_W] = q.prios[i*PRIO_W +: PRIO_W];
			end
		end
		// Data stand only in the cycle after the strobe
		// Zero outside the answer cycle keeps the bus quiet
		d.rdata = RD_STROBE_IN ? rd_word : '0;

		// Mask register
		// The mask never stops a status bit from setting
		if (WR_STROBE_IN && (ADDR_IN == ADDR_IRQ_MASK))
			d.irq_mask = WDATA_IN[IRQ_W-1:0];

		// Sticky events; read clears, a new event in that cycle survives
		// A new pending vector shows as a rising request line
		// Clear first, set after, so no event is lost
		events[IRQ_PEND_BIT] = d.pend_valid & ~q.pend_valid;
		events[IRQ_TRAP_BIT] = |(TRAP_IN & TRAP_IMPL);
		if (RD_STROBE_IN && (ADDR_IN == ADDR_IRQ_STAT))
			d.irq_stat = '0;
		d.irq_stat = d.irq_stat | events;
	end

	// State register; reset values are constants only
	// Reset must leave in step with the clock; no synchroniser here
	// Constants only in the reset branch keep recovery simple
	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			q                       <= '0;
			q.gc1                   <= RST_GC1;
			q.gc2                   <= RST_GC2;
			{q.ipl_msb, q.ipl_low}  <= RST_CPU_LEVEL;
			q.irq_mask              <= RST_IRQ_MASK;
		end
		else
			q <= d;
	end

	// Outputs straight from state flops, except IRQ_OUT, gated from the status and mask flops
	// Pending vector and level keep their last value while idle; the address follows the table select
	assign RDATA_OUT          = q.rdata;
	assign INT_REQ_OUT        = q.pend_valid;
	assign PENDING_VECTOR_OUT = q.pend_vec;
	assign PENDING_LEVEL_OUT  = q.pend_lvl;
	assign VECTOR_ADDR_OUT    = q.vec_addr;
	assign CPU_LEVEL_OUT      = {q.ipl_msb, q.ipl_low};
	// Level interrupt while any unmasked event is held
	// Only two events exist; the upper status bits read zero
	assign IRQ_OUT            = |(q.irq_stat & q.irq_mask);

endmodule

/* verif/vpic_core_model.sv */
`timescale 1ns/100ps
module vpic_core_model
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// Request and behaviour
	input  wire logic       req_in,
	input  wire logic       ack_en_in,
	input  wire logic [3:0] delay_in,
	// Acknowledge pulse
	output logic            ack_out
);
	logic [3:0] wait_q; // Cycles request has waited

	// Core takes a request after a chosen delay; never acks an absent one
	always_ff @(posedge clk_in or posedge reset_in)
		if (reset_in)
		begin
			ack_out <= 1'b0;
			wait_q  <= 4'h0;
		end
		else
		begin
			ack_out <= 1'b0;
			if (ack_out || !req_in || !ack_en_in)
				wait_q <= 4'h0;
			else if (wait_q == delay_in)
				ack_out <= 1'b1;
			else
				wait_q <= wait_q + 4'h1;
		end
endmodule

/* verif/vpic_tb_top.sv */
`timescale 1ns/100ps
module vpic_tb_top import vpic_pkg::*;
;
	// Stimulus and observed signals
	logic                clk, rst, wr_s, rd_s, ack, restore, ack_en, int_req, irq;
	logic [AW-1:0]       addr;
	logic [DW-1:0]       wdata, rdata;
	logic [NUM_SRC-1:0]  periph;
	logic [NUM_EXT-1:0]  ext;
	logic [NUM_TRAP-1:0] trap;
	logic [LVL_W-1:0]    rlevel, plvl, cpu_lvl;
	logic [VEC_W-1:0]    pvec;
	logic [TADDR_W-1:0]  vaddr;
	int                  miscompares, checks, cycles;

	vpic_top uut (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_STROBE_IN(wr_s),
		.RD_STROBE_IN(rd_s), .RDATA_OUT(rdata), .PERIPH_REQ_IN(periph), .EXT_PIN_IN(ext), .TRAP_IN(trap),
		.INT_REQ_OUT(int_req), .PENDING_VECTOR_OUT(pvec), .PENDING_LEVEL_OUT(plvl), .VECTOR_ADDR_OUT(vaddr),
		.INT_ACK_IN(ack), .RESTORE_IN(restore), .RESTORE_LEVEL_IN(rlevel), .CPU_LEVEL_OUT(cpu_lvl),
		.IRQ_OUT(irq));
	vpic_core_model core (.clk_in(clk), .reset_in(rst), .req_in(int_req), .ack_en_in(ack_en),
		.delay_in(4'h2), .ack_out(ack));

	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard; run needs about 230 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One-cycle register write
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Read; data stands only in the following cycle
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk("rdata", rdata, exp);
	endtask

	task automatic fire(input int n);
		@(posedge clk);
		periph <= {{NUM_SRC-1{1'b0}}, 1'b1} << n;
		@(posedge clk);
		periph <= {NUM_SRC{1'b0}};
	endtask

	// Pin path takes five cycles, so a wait of eight is safe
	task automatic pend(input logic [23:0] v, input logic [23:0] l, input logic [23:0] a);
		repeat (8) @(posedge clk);
		#1 chk("int_req", int_req, 24'h1);
		chk("vector", pvec, v);
		chk("level", plvl, l);
		chk("address", vaddr, a);
	endtask

	task automatic idle();
		repeat (8) @(posedge clk);
		#1 chk("int_req", int_req, 24'h0);
	endtask

	// Software is the only party that clears flags
	task automatic clr();
		for (int w = 0; w < FLAG_REGS; w++)
			wr(AW'(ADDR_FLAG_BASE + w), 16'h0000);
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		{wr_s, rd_s, restore, ack_en, addr, wdata, periph, ext, trap, rlevel} <= '0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// Reset values, unmapped index, read-only msb
		rd(ADDR_GC1, RST_GC1);
		rd(ADDR_GC2, RST_GC2);
		wr(8'h30, 16'hffff);
		rd(8'h30, 16'h0000);
		wr(ADDR_CORE_CTRL, 16'h0008);
		rd(ADDR_CORE_CTRL, 16'h0000);
		// Level bits writable unless nesting disabled
		wr(ADDR_STATUS_WD, 16'h00ff);
		rd(ADDR_STATUS_WD, 16'h00e0);
		chk("cpu_level", cpu_lvl, 24'h7);
		wr(ADDR_GC1, 16'h8000);
		wr(ADDR_STATUS_WD, 16'h0000);
		rd(ADDR_STATUS_WD, 16'h00e0);
		wr(ADDR_GC1, 16'h0000);
		wr(ADDR_STATUS_WD, 16'h0000);
		rd(ADDR_STATUS_WD, 16'h0000);
		// Disabled source, then enabled, then priority zero
		wr(ADDR_PRIO_BASE, 16'h5000);
		fire(3);
		idle();
		rd(ADDR_FLAG_BASE, 16'h0008);
		wr(ADDR_EN_BASE, 16'h0028);
		pend(11, 5, 24'h1a);
		wr(ADDR_PRIO_BASE, 16'h0000);
		idle();
		// Equal priority tie, then higher priority wins
		wr(ADDR_PRIO_BASE, 16'h5000);
		wr(8'h11, 16'h0050);
		fire(5);
		pend(11, 5, 24'h1a);
		wr(8'h11, 16'h0060);
		pend(13, 6, 24'h1e);
		rd(ADDR_PEND, 16'h060d);
		// Core takes it; flags stay until software clears
		ack_en <= 1'b1;
		repeat (8) @(posedge clk);
		#1 chk("cpu_level", cpu_lvl, 24'h6);
		chk("int_req", int_req, 24'h0);
		ack_en <= 1'b0;
		rd(ADDR_FLAG_BASE, 16'h0028);
		@(posedge clk);
		restore <= 1'b1;
		@(posedge clk);
		restore <= 1'b0;
		pend(13, 6, 24'h1e);
		clr();
		idle();
		// Request 53 in both tables
		wr(8'h0b, 16'h0060);
		wr(8'h1d, 16'h0430);
		fire(53);
		pend(61, 3, 24'h7e);
		rd(8'h05, 16'h0020);
		wr(ADDR_GC2, 16'h8000);
		pend(61, 3, 24'h17e);
		rd(ADDR_GC2, 16'h8000);
		// External pin four, rising edge
		@(posedge clk);
		ext <= 5'h10;
		pend(62, 4, 24'h180);
		wr(ADDR_GC2, 16'h0000);
		pend(62, 4, 24'h80);
		// Falling edge on the same pin, polarity switch makes no edge
		clr();
		wr(ADDR_GC2, 16'h0010);
		idle();
		ext <= 5'h00;
		pend(62, 4, 24'h80);
		// Trap outranks user; interrupt masked, raised, cleared
		wr(ADDR_IRQ_MASK, 16'h0002);
		#1 chk("irq", irq, 24'h0);
		@(posedge clk);
		trap <= 8'h02;
		@(posedge clk);
		trap <= 8'h00;
		pend(1, 14, 24'h06);
		chk("irq", irq, 24'h1);
		rd(ADDR_GC1, 16'h0002);
		rd(ADDR_IRQ_STAT, 16'h0003);
		chk("irq", irq, 24'h0);
		// Core takes the trap; the level msb then holds off users
		ack_en <= 1'b1;
		repeat (8) @(posedge clk);
		#1 chk("cpu_level", cpu_lvl, 24'he);
		chk("int_req", int_req, 24'h0);
		rd(ADDR_CORE_CTRL, 16'h0008);
		rd(ADDR_STATUS_WD, 16'h00c0);
		tally_and_finish();
	end
endmodule

/* verif/vpic_top_properties.sv */
`timescale 1ns/100ps
module vpic_top_properties import vpic_pkg::*;
(
	// Clock and reset
	input wire logic                 CLK_IN,
	input wire logic                 RESET_IN,
	// Register port
	input wire logic                 RD_STROBE_IN,
	input wire logic [DW-1:0]        RDATA_OUT,
	// Events and core side
	input wire logic [NUM_TRAP-1:0]  TRAP_IN,
	input wire logic                 INT_REQ_OUT,
	input wire logic [VEC_W-1:0]     PENDING_VECTOR_OUT,
	input wire logic [LVL_W-1:0]     PENDING_LEVEL_OUT,
	input wire logic [TADDR_W-1:0]   VECTOR_ADDR_OUT,
	input wire logic                 INT_ACK_IN,
	input wire logic                 RESTORE_IN,
	input wire logic [LVL_W-1:0]     RESTORE_LEVEL_IN,
	input wire logic [LVL_W-1:0]     CPU_LEVEL_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	// Short names for the pending fields
	wire logic [VEC_W-1:0] vec = PENDING_VECTOR_OUT;
	wire logic             usr = INT_REQ_OUT && (vec >= 7'h08);

	// Entry address follows vector; alt offset only moves bit 8
	property p_addr;
		INT_REQ_OUT |-> VECTOR_ADDR_OUT[7:0] == 8'h04 + {vec, 1'b0} && VECTOR_ADDR_OUT[23:9] == 15'h0000;
	endproperty
	property p_vec_range;
		INT_REQ_OUT |-> vec inside {[1:5], [8:79]};
	endproperty
	property p_trap_lvl;
		INT_REQ_OUT && vec < 7'h08 |-> PENDING_LEVEL_OUT == 4'hf - vec[3:0];
	endproperty
	// Level steady for three cycles, so arbiter lag cannot trip it
	property p_user_lvl;
		usr && CPU_LEVEL_OUT == $past(CPU_LEVEL_OUT, 3) |->
			PENDING_LEVEL_OUT inside {[1:7]} && PENDING_LEVEL_OUT > CPU_LEVEL_OUT;
	endproperty
	property p_msb_block;
		CPU_LEVEL_OUT[3] && CPU_LEVEL_OUT == $past(CPU_LEVEL_OUT, 3) |-> !usr;
	endproperty
	property p_ack;
		INT_ACK_IN && INT_REQ_OUT && !RESTORE_IN |=> CPU_LEVEL_OUT == $past(PENDING_LEVEL_OUT);
	endproperty
	property p_restore;
		RESTORE_IN |=> CPU_LEVEL_OUT == $past(RESTORE_LEVEL_IN);
	endproperty
	property p_rdata_idle;
		!RD_STROBE_IN |=> RDATA_OUT == 16'h0000;
	endproperty
	// Oscillator trap outranks everything
	property p_osc_trap;
		TRAP_IN[1] && CPU_LEVEL_OUT < 4'he && !INT_ACK_IN && !RESTORE_IN |->
			##[1:2] (INT_REQ_OUT && vec == 7'h01 && PENDING_LEVEL_OUT == 4'he);
	endproperty

	a_addr: assert property (p_addr) else $error("vector address wrong");
	a_vec_range: assert property (p_vec_range) else $error("vector out of range");
	a_trap_lvl: assert property (p_trap_lvl) else $error("trap level wrong");
	a_user_lvl: assert property (p_user_lvl) else $error("user level wrong");
	a_msb_block: assert property (p_msb_block) else $error("user not blocked");
	a_ack: assert property (p_ack) else $error("ack level wrong");
	a_restore: assert property (p_restore) else $error("restore level wrong");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	a_osc_trap: assert property (p_osc_trap) else $error("trap not pending");

	// Main scenarios reached
	c_trap: cover property (INT_REQ_OUT && vec == 7'h01);
	c_alt: cover property (INT_REQ_OUT && VECTOR_ADDR_OUT[8]);
	c_ack: cover property (INT_ACK_IN && INT_REQ_OUT);
endmodule

bind vpic_top vpic_top_properties u_props (.CLK_IN, .RESET_IN, .RD_STROBE_IN, .RDATA_OUT, .TRAP_IN,
	.INT_REQ_OUT, .PENDING_VECTOR_OUT, .PENDING_LEVEL_OUT, .VECTOR_ADDR_OUT, .INT_ACK_IN,
	.RESTORE_IN, .RESTORE_LEVEL_IN, .CPU_LEVEL_OUT);
